// ### rtl/see_cfg.svh
// constants of the serial eeprom command engine
// assumes: included by bare name from package and design files
`ifndef SEE_CFG_SVH
`define SEE_CFG_SVH
// control byte layout
`define SEE_TYPE_CODE   4'ha
`define SEE_TYPE_HI     7
`define SEE_TYPE_LO     4
`define SEE_BLOCK_BIT   3
`define SEE_CS_HIGH_BIT 2
`define SEE_CS_LOW_BIT  1
`define SEE_DIR_BIT     0
// array and page geometry
`define SEE_ADDR_W      17
`define SEE_PAGE_W      7
`define SEE_PAGE_LAST   7'h7f
// timing: system clock period and internal write time
`define SEE_CLK_NS      100
`define SEE_TWR_NS      5000000
`define SEE_TWR_CYC     (`SEE_TWR_NS / `SEE_CLK_NS)
`endif

// ### rtl/see_pkg.sv
// types of the serial eeprom command engine
// assumes: see_cfg.svh supplies the widths
`include "see_cfg.svh"
package see_pkg;
    // link-side protocol states
    typedef enum logic [2:0] {
        ST_IDLE, ST_CTRL, ST_ADRH, ST_ADRL, ST_WDATA, ST_RDATA, ST_IGNORE
    } see_state_e;
    // pins sampled on the link clock
    typedef struct packed {
        logic scl;
        logic sda;
        logic wp;
        logic csLow;
        logic csHigh;
    } see_pins_s;
    // all state of the link domain
    typedef struct packed {
        logic                       rstA;
        logic                       rstB;
        see_pins_s                  pinA;
        see_pins_s                  pinB;
        logic                       sclPrev;
        logic                       sdaPrev;
        see_state_e                 state;
        logic [3:0]                 bitCnt;
        logic [7:0]                 shift;
        logic [7:0]                 txByte;
        logic                       mAck;
        logic                       driveN;
        logic                       sdaOut;
        logic [`SEE_ADDR_W-1:0]     ptr;
        logic [`SEE_ADDR_W-`SEE_PAGE_W-1:0] pageBase;
        logic [(1<<`SEE_PAGE_W)-1:0] mask;
        logic                       gotData;
        logic                       busy;
        logic                       copying;
        logic [`SEE_PAGE_W-1:0]     copyIdx;
        logic                       timerOver;
        logic                       commitTog;
        logic                       doneA;
        logic                       doneB;
        logic                       donePrev;
    } see_link_s;
    // all state of the system domain
    typedef struct packed {
        logic        reqA;
        logic        reqB;
        logic        reqPrev;
        logic        busy;
        logic [31:0] count;
        logic        doneTog;
    } see_sys_s;
endpackage : see_pkg

// ### rtl/see_command_engine.sv
// slave command logic of a two-wire serial eeprom with page buffer
// assumes: scl/sda/wp/chip-select pins are asynchronous to both clocks;
// sda is open drain, resolved outside from sdaOut and sdaDriveN
`include "see_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module see_command_engine #(
    parameter int WRITE_CYCLES = `SEE_TWR_CYC   // internal write length in clk_sys cycles
) (
    // system side
    input  wire logic clk_sys,
    input  wire logic rst,
    // link side clock, oversamples the bus
    input  wire logic linkClk,
    // bus pins
    input  wire logic sclIn,
    input  wire logic sdaIn,
    output logic      sdaOut,
    output logic      sdaDriveN,
    // straps and protection pins
    input  wire logic wpIn,
    input  wire logic chipSelectLowIn,
    input  wire logic chipSelectHighIn,
    // status
    output logic      writeBusy
);
    localparam int AW = `SEE_ADDR_W;
    localparam int PW = `SEE_PAGE_W;

    // ------------------------------------------------------------
    // design notes
    // ------------------------------------------------------------
    // clocking: the bus is oversampled on linkClk; scl is never used as a
    // clock, so every bus event is an edge seen on synced pin copies.
    // linkClk must run at least about eight times faster than scl, or a
    // short high or low phase slips between two samples and a bit is lost.
    // each pin passes two flops, and one more stage keeps the previous
    // level for edge detection; total lag from pin to decision is two to
    // three linkClk periods, well inside the scl low phase.
    // start and stop are checked before scl edges, so a data change with
    // scl high is never mistaken for a bit.
    // the ack is driven after the eighth scl fall and released after the
    // ninth; the drive always changes while scl is low.
    // sda is open drain: sdaOut stays low and only sdaDriveN moves, low
    // while the pin is pulled. a one bit of read data is a release.
    // writes land in the page buffer first; a mask marks which slots hold
    // fresh bytes, so slots never written keep the old array contents.
    // at stop the copy engine walks all page slots in one pass, one slot
    // per linkClk, while the system timer counts the write time.
    // busy on the link side covers both the copy and the timer; a short
    // timer therefore cannot open the bus before the copy has finished.
    // while busy every addressed control byte is refused, which is a
    // superset of refusing only the byte that started the write.
    // the timer lives on clk_sys; the start and the end cross as toggles
    // on two flops each, so no multi-bit word crosses between domains.
    // write protect is sampled once, at the stop of the write; a change
    // afterwards has no effect on a cycle that is already running.
    // the arrays carry no reset: their contents are unknown until written,
    // as on a blank part.
    // limitation: an address-only write (stop with no data byte) loads the
    // pointer and starts no write cycle.

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0]          memArray [0:(1<<AW)-1];    // nonvolatile array model
    logic [7:0]          pageBuf  [0:(1<<PW)-1];    // page write buffer
    see_pkg::see_link_s  lk;                        // link state
    see_pkg::see_link_s  ln;                        // its next value
    see_pkg::see_sys_s   sy;                        // system state
    see_pkg::see_sys_s   sn;                        // its next value
    logic                memWe;                     // array write strobe
    logic [AW-1:0]       memAddr;                   // array write address
    logic [7:0]          memData;                   // array write data
    logic                bufWe;                     // buffer write strobe
    logic [PW-1:0]       bufAddr;                   // buffer slot
    logic                sclRise;                   // bus edges
    logic                sclFall;
    logic                startCond;
    logic                stopCond;
    logic                ctrlMatch;                 // control byte addresses us
    logic [AW-1:0]       ptrNextRd;                 // read pointer, half wrap

    // ------------------------------------------------------------
    // link domain: next state
    // ------------------------------------------------------------
    // one process for the whole bus engine; edges come from synced pins
    always_comb begin
        ln = lk;
        memWe   = 1'b0;
        memAddr = {lk.pageBase, lk.copyIdx};
        memData = pageBuf[lk.copyIdx];
        bufWe   = 1'b0;
        bufAddr = lk.ptr[PW-1:0];
        // two flops on every pin before use
        ln.pinA = '{scl: sclIn, sda: sdaIn, wp: wpIn, csLow: chipSelectLowIn, csHigh: chipSelectHighIn};
        ln.pinB = lk.pinA;
        ln.sclPrev = lk.pinB.scl;
        ln.sdaPrev = lk.pinB.sda;
        ln.rstA = rst;
        ln.rstB = lk.rstA;
        // done toggle from the timer crosses on two flops
        ln.doneA = sy.doneTog;
        ln.doneB = lk.doneA;
        ln.donePrev = lk.doneB;
        sclRise   = lk.pinB.scl & ~lk.sclPrev;
        sclFall   = ~lk.pinB.scl & lk.sclPrev;
        startCond = lk.pinB.scl & lk.sclPrev & ~lk.pinB.sda & lk.sdaPrev;
        stopCond  = lk.pinB.scl & lk.sclPrev & lk.pinB.sda & ~lk.sdaPrev;
        ctrlMatch = (lk.shift[`SEE_TYPE_HI:`SEE_TYPE_LO] == `SEE_TYPE_CODE) &&
                    (lk.shift[`SEE_CS_HIGH_BIT] == lk.pinB.csHigh) &&
                    (lk.shift[`SEE_CS_LOW_BIT] == lk.pinB.csLow);
        // reads stay inside the half chosen by the top bit
        ptrNextRd = {lk.ptr[AW-1], lk.ptr[AW-2:0] + {{(AW-2){1'b0}}, 1'b1}};

        // copy engine: buffered bytes go to the array during busy
        if (lk.copying) begin
            memWe = lk.mask[lk.copyIdx];
            ln.copyIdx = lk.copyIdx + {{(PW-1){1'b0}}, 1'b1};
            if (lk.copyIdx == `SEE_PAGE_LAST) begin
                ln.copying = 1'b0;
            end
        end
        // timer end is kept until the copy is over as well
        if (lk.doneB != lk.donePrev) begin
            ln.timerOver = 1'b1;
        end
        if (lk.busy && (lk.timerOver || lk.doneB != lk.donePrev) && !lk.copying) begin
            ln.busy = 1'b0;
            ln.timerOver = 1'b0;
        end

        // bus protocol; start and stop win over clock edges
        if (startCond) begin
            ln.state  = see_pkg::ST_CTRL;
            ln.bitCnt = 4'h0;
            ln.driveN = 1'b1;
        end else if (stopCond) begin
            ln.state  = see_pkg::ST_IDLE;
            ln.driveN = 1'b1;
            ln.gotData = 1'b0;
            // a write ends here; protect pin sampled now
            if (lk.state == see_pkg::ST_WDATA && lk.gotData && !lk.busy && !lk.pinB.wp) begin
                ln.busy      = 1'b1;
                ln.copying   = 1'b1;
                ln.copyIdx   = '0;
                ln.commitTog = ~lk.commitTog;
            end
            // protected: buffer is dropped and we stay ready at once
        end else if (sclRise) begin
            // sample data bits, then the master's ack bit
            if (lk.bitCnt < 4'h8) begin
                ln.shift  = {lk.shift[6:0], lk.pinB.sda};
                ln.bitCnt = lk.bitCnt + 4'h1;
            end else if (lk.bitCnt == 4'h8) begin
                ln.mAck   = ~lk.pinB.sda;
                ln.bitCnt = 4'h9;
            end
        end else if (sclFall) begin
            if (lk.bitCnt == 4'h8) begin
                // byte done: decide ack for the ninth clock
                ln.driveN = 1'b1;
                unique case (lk.state)
                    see_pkg::ST_CTRL: begin
                        // busy: no ack to our control byte
                        if (ctrlMatch && !lk.busy) begin
                            ln.driveN = 1'b0;
                            ln.ptr[AW-1] = lk.shift[`SEE_BLOCK_BIT];
                            if (lk.shift[`SEE_DIR_BIT]) begin
                                ln.state = see_pkg::ST_RDATA;
                            end else begin
                                ln.state = see_pkg::ST_ADRH;
                            end
                        end else begin
                            ln.state = see_pkg::ST_IGNORE;
                        end
                    end
                    see_pkg::ST_ADRH: begin
                        ln.ptr[AW-2:8] = lk.shift;
                        ln.driveN = 1'b0;
                        ln.state  = see_pkg::ST_ADRL;
                    end
                    see_pkg::ST_ADRL: begin
                        // pointer is kept even if a restart follows
                        ln.ptr[7:0] = lk.shift;
                        ln.driveN   = 1'b0;
                        ln.mask     = '0;
                        ln.gotData  = 1'b0;
                        ln.state    = see_pkg::ST_WDATA;
                    end
                    see_pkg::ST_WDATA: begin
                        // store in buffer, bump low bits only, wrap in page
                        bufWe = 1'b1;
                        ln.mask[lk.ptr[PW-1:0]] = 1'b1;
                        ln.ptr[PW-1:0] = lk.ptr[PW-1:0] + {{(PW-1){1'b0}}, 1'b1};
                        ln.pageBase = lk.ptr[AW-1:PW];
                        ln.gotData  = 1'b1;
                        ln.driveN   = 1'b0;
                    end
                    see_pkg::ST_RDATA: begin
                        // release for master ack, step to next byte
                        ln.ptr = ptrNextRd;
                    end
                    default: begin
                        ln.driveN = 1'b1;
                    end
                endcase
            end else if (lk.bitCnt == 4'h9) begin
                // end of ack clock
                ln.bitCnt = 4'h0;
                ln.driveN = 1'b1;
                if (lk.state == see_pkg::ST_RDATA) begin
                    if (lk.shift[`SEE_DIR_BIT] && lk.txByte == 8'h00 && lk.mAck == 1'b0 &&
                        lk.driveN == 1'b0) begin
                        // first byte after our ack of a read control byte
                        ln.txByte = memArray[lk.ptr];
                        ln.driveN = memArray[lk.ptr][7];
                    end else if (lk.mAck || lk.driveN == 1'b0) begin
                        ln.txByte = memArray[lk.ptr];
                        ln.driveN = memArray[lk.ptr][7];
                    end else begin
                        ln.state = see_pkg::ST_IGNORE;
                    end
                    ln.mAck = 1'b0;
                end
            end else if (lk.state == see_pkg::ST_RDATA && lk.bitCnt != 4'h0) begin
                // shift out the remaining bits, msb first
                ln.driveN = lk.txByte[3'(4'h7 - lk.bitCnt)];
            end
        end

        // synchronous reset of the link domain
        if (lk.rstB) begin
            ln = '0;
            ln.rstA = rst;
            ln.rstB = lk.rstA;
            // synchronisers keep running through reset; only the second
            // flop feeds the rest, and the edge history follows the pins
            ln.pinA = '{scl: sclIn, sda: sdaIn, wp: wpIn, csLow: chipSelectLowIn, csHigh: chipSelectHighIn};
            ln.pinB = lk.pinA;
            // previous levels track the bus, so no false edge after reset
            ln.sclPrev = lk.pinB.scl;
            ln.sdaPrev = lk.pinB.sda;
            ln.driveN = 1'b1;
            ln.state = see_pkg::ST_IDLE;
        end
    end

    // ------------------------------------------------------------
    // link domain: registers and memories
    // ------------------------------------------------------------
    // state struct on the link clock
    always_ff @(posedge linkClk) begin
        lk <= ln;
    end

    // buffer and array ports; arrays are not reset
    always_ff @(posedge linkClk) begin
        if (bufWe) begin
            pageBuf[bufAddr] <= lk.shift;
        end
        if (memWe) begin
            memArray[memAddr] <= memData;
        end
    end

    // ------------------------------------------------------------
    // system domain: write timer
    // ------------------------------------------------------------
    // a commit toggle starts the count; done goes back as a toggle
    // the counter runs only while busy; it restarts from zero at each
    // commit, so a commit that arrives while idle always gets a full count.
    // a new commit cannot arrive while busy, since the link refuses all
    // control bytes until the done toggle has come back.
    // trade-off: a 32-bit counter is wider than needed, but any write
    // length that fits an int can be chosen without touching the logic.
    always_comb begin
        sn = sy;
        sn.reqA = lk.commitTog;
        sn.reqB = sy.reqA;
        sn.reqPrev = sy.reqB;
        if (sy.busy) begin
            if (sy.count == 32'(WRITE_CYCLES - 1)) begin
                sn.busy = 1'b0;
                sn.doneTog = ~sy.doneTog;
            end else begin
                sn.count = sy.count + 32'h1;
            end
        end else if (sy.reqB != sy.reqPrev) begin
            sn.busy  = 1'b1;
            sn.count = '0;
        end
        if (rst) begin
            sn = '0;
        end
    end

    // state struct on the system clock
    always_ff @(posedge clk_sys) begin
        sy <= sn;
    end

    // ------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------
    // writeBusy lags the stop by a few clk_sys cycles for the crossing;
    // the link side is already refusing control bytes during that gap.
    // sdaOut is a constant low flop, the pin is only ever pulled down.
    assign sdaOut    = lk.sdaOut;
    assign sdaDriveN = lk.driveN;
    assign writeBusy = sy.busy;
endmodule : see_command_engine
`default_nettype wire

// ### test/see_master_model.sv
// bus master model: drives scl and its own pull on data
// assumes: steps on falling clk_sys edges, pull-up on data
`timescale 1ns/1ns
`default_nettype none
module see_master_model (
    // pacing
    input  wire logic clk_sys,
    // slave pull on data
    input  wire logic sdaOut,
    input  wire logic sdaDriveN,
    // resolved bus
    output logic      scl,
    output logic      sda
);
    logic sdaM; // master pull, 1 = released
    // pull-up wins unless a party pulls low
    assign sda = sdaM & (sdaDriveN | sdaOut);
    initial begin
        scl = 1'b1;
        sdaM = 1'b1;
    end
    // one quarter of a bus clock
    task tick();
        @(negedge clk_sys);
    endtask : tick
    // one bit out, line sampled in the high phase
    task bitx(input logic b, output logic s);
        sdaM = b;
        tick();
        scl = 1'b1;
        tick();
        tick();
        s = sda;
        scl = 1'b0;
        tick();
    endtask : bitx
    // start or repeated start, ends with scl low
    task start();
        sdaM = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        sdaM = 1'b0;
        tick();
        scl = 1'b0;
        tick();
    endtask : start
    // stop, leaves bus idle
    task stop();
        sdaM = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        sdaM = 1'b1;
        tick();
    endtask : stop
    // msb first, then release for the ack clock
    task sendByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(b[i], s);
        end
        bitx(1'b1, ack);
    endtask : sendByte
    // receive, then ack (0) or nack (1)
    task recvByte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, b[i]);
        end
        bitx(nack, s);
    endtask : recvByte
endmodule : see_master_model
`default_nettype wire

// ### test/see_command_engine_asserts.sv
// checker on the engine's ports, bound below
// assumes: pins sampled raw on linkClk, busy on clk_sys
`timescale 1ns/1ns
`default_nettype none
module see_command_engine_asserts #(
    parameter int WRITE_CYCLES = 40
) (
    // clocks and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic linkClk,
    // bus
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaDriveN,
    // straps and status
    input wire logic wpIn,
    input wire logic chipSelectLowIn,
    input wire logic chipSelectHighIn,
    input wire logic writeBusy
);
    logic [31:0] busyCnt_reg; // busy samples so far
    logic [7:0]  fallCnt_reg; // scl falls since start
    logic        sclQ_reg;
    logic        sdaQ_reg;
    // busy length counter
    always_ff @(posedge clk_sys) begin
        busyCnt_reg <= (rst || !writeBusy) ? 32'h0 : busyCnt_reg + 32'h1;
    end
    // falls counted from start; saturates so it never wraps to a false ack slot
    always_ff @(posedge linkClk) begin
        sclQ_reg <= sclIn;
        sdaQ_reg <= sdaIn;
        if (rst || (sclIn && sclQ_reg && sdaQ_reg && !sdaIn)) begin
            fallCnt_reg <= 8'h00;
        end else if (sclQ_reg && !sclIn && fallCnt_reg != 8'hff) begin
            fallCnt_reg <= fallCnt_reg + 8'h01;
        end
    end
    a_drive_low_clk: assert property (@(posedge linkClk) disable iff (rst) $fell(sdaDriveN) |-> !sclIn)
        else $error("drive began with clock high");
    a_ack_ninth: assert property (@(posedge linkClk) disable iff (rst) $fell(sdaDriveN) |-> fallCnt_reg >= 8'h09)
        else $error("drive began before ninth clock");
    a_busy_silent: assert property (@(posedge linkClk) disable iff (rst) writeBusy |-> sdaDriveN)
        else $error("pull while writing");
    a_open_drain: assert property (@(posedge linkClk) disable iff (rst) !sdaDriveN |-> sdaOut == 1'b0)
        else $error("data driven high");
    a_link_reset: assert property (@(posedge linkClk) disable iff (rst) $fell(rst) |-> sdaDriveN)
        else $error("pull after reset");
    a_busy_length: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(writeBusy) |-> busyCnt_reg == 32'(WRITE_CYCLES))
        else $error("busy length wrong");
    a_busy_holds: assert property (@(posedge clk_sys) disable iff (rst) $rose(writeBusy) |=> writeBusy[*8])
        else $error("busy too short");
    a_busy_reset: assert property (@(posedge clk_sys) disable iff (rst) $fell(rst) |-> !writeBusy)
        else $error("busy after reset");
    // main scenarios
    c_write: cover property (@(posedge clk_sys) $rose(writeBusy));
    c_ack: cover property (@(posedge linkClk) $fell(sdaDriveN) && fallCnt_reg == 8'h09);
    c_read: cover property (@(posedge linkClk) $fell(sdaDriveN) && fallCnt_reg > 8'h12);
endmodule : see_command_engine_asserts
bind see_command_engine see_command_engine_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
    .clk_sys(clk_sys), .rst(rst), .linkClk(linkClk), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaDriveN(sdaDriveN), .wpIn(wpIn), .chipSelectLowIn(chipSelectLowIn),
    .chipSelectHighIn(chipSelectHighIn), .writeBusy(writeBusy));
`default_nettype wire

// ### test/see_command_engine_bench.sv
// self-checking bench: bus master model plus command tasks
// assumes: chip pins strapped high/low = 0/1
`timescale 1ns/1ns
`default_nettype none
module see_command_engine_bench;
    localparam int WRITE_CYCLES = 40; // short, still above the copy time
    logic clk_sys = 1'b0;
    logic linkClk = 1'b0;
    logic rst = 1'b1;
    logic wpIn = 1'b0;
    logic sclIn;
    logic sdaIn;
    logic sdaOut;
    logic sdaDriveN;
    logic writeBusy;
    int   mismatches = 0;
    int   num_checks = 0;
    logic [7:0] badCtrl [3] = '{8'hb2, 8'ha4, 8'ha0}; // wrong type, wrong chip bits
    // clocks, link offset so phases never line up
    always #50 clk_sys = ~clk_sys;
    always begin
        #8 linkClk = 1'b1;
        #7 linkClk = 1'b0;
    end
    see_command_engine #(.WRITE_CYCLES(WRITE_CYCLES)) uut (
        .clk_sys(clk_sys), .rst(rst), .linkClk(linkClk), .sclIn(sclIn), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaDriveN(sdaDriveN), .wpIn(wpIn), .chipSelectLowIn(1'b1),
        .chipSelectHighIn(1'b0), .writeBusy(writeBusy));
    see_master_model master (.clk_sys(clk_sys), .sdaOut(sdaOut), .sdaDriveN(sdaDriveN), .scl(sclIn), .sda(sdaIn));
    // compare and count
    task check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    // verdict
    task test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    // control byte for this strapping
    function logic [7:0] ctrl(input logic blk, input logic rd);
        return {4'ha, blk, 1'b0, 1'b1, rd};
    endfunction : ctrl
    // one byte out with expected ack level
    task put(input logic [7:0] b, input logic expAck);
        logic a;
        master.sendByte(b, a);
        check({7'h00, a}, {7'h00, expAck});
    endtask : put
    // start, write control, address high then low
    task setPtr(input logic [16:0] a);
        master.start();
        put(ctrl(a[16], 1'b0), 1'b0);
        put(a[15:8], 1'b0);
        put(a[7:0], 1'b0);
    endtask : setPtr
    // write, stop with wp at prot, then poll with wp high
    task writeBytes(input logic [16:0] a, input logic [7:0] d[$], input logic prot);
        int   polls;
        logic ack;
        setPtr(a);
        foreach (d[i]) put(d[i], 1'b0);
        wpIn = prot;
        master.stop();
        wpIn = 1'b1;
        polls = 0;
        do begin
            master.start();
            master.sendByte(ctrl(a[16], 1'b0), ack);
            polls++;
        end while (ack !== 1'b0 && polls < 50);
        master.stop();
        wpIn = 1'b0;
        check({7'h00, ack}, 8'h00);
        check({7'h00, polls > 1}, {7'h00, !prot});
    endtask : writeBytes
    // random (rnd) or current read, ack all but last
    task readBytes(input logic rnd, input logic [16:0] a, input logic [7:0] e[$]);
        logic [7:0] b;
        if (rnd) setPtr(a);
        master.start();
        put(ctrl(a[16], 1'b1), 1'b0);
        foreach (e[i]) begin
            master.recvByte(i == e.size() - 1, b);
            check(b, e[i]);
        end
        master.stop();
    endtask : readBytes
    // watchdog: whole run needs some 2800 cycles
    initial begin
        repeat (40000) @(posedge clk_sys);
        mismatches++;
        test_done();
    end
    // main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        foreach (badCtrl[i]) begin
            master.start();
            put(badCtrl[i], 1'b1);
            master.stop();
        end
        $display("test refused done");
        writeBytes(17'h0007e, '{8'h11, 8'h22, 8'h33, 8'h44}, 1'b0);
        writeBytes(17'h00000, '{8'h5a}, 1'b0);
        readBytes(1'b0, 17'h00000, '{8'h44});
        readBytes(1'b1, 17'h0007e, '{8'h11});
        readBytes(1'b0, 17'h00000, '{8'h22});
        readBytes(1'b1, 17'h00000, '{8'h5a, 8'h44});
        $display("test page and pointer done");
        writeBytes(17'h0ffff, '{8'h66}, 1'b0);
        writeBytes(17'h1ffff, '{8'h77}, 1'b0);
        writeBytes(17'h10000, '{8'h88}, 1'b0);
        readBytes(1'b1, 17'h0ffff, '{8'h66, 8'h5a});
        readBytes(1'b1, 17'h1ffff, '{8'h77, 8'h88});
        $display("test wrap done");
        writeBytes(17'h00000, '{8'h99}, 1'b1);
        readBytes(1'b1, 17'h00000, '{8'h5a});
        $display("test protect done");
        test_done();
    end
endmodule : see_command_engine_bench
`default_nettype wire
